// ==== logic/scs_glitchless.sv ====
// Glitch-free clock mux sequencer: gates the clock off, then swaps source and reopens on the same edge
module scs_glitchless #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Requested and committed source code
    input wire logic [W-1:0] req_in,
    output logic [W-1:0] sel_out,
    output logic gate_out
);
    typedef struct packed {
        scs_pkg::scs_sw_e state;
        logic [scs_pkg::SETTLE_W-1:0] cnt;
        logic [W-1:0] cur;
    } scs_glitch_s;

    scs_glitch_s st;
    scs_glitch_s next_st;

    // Outside reset a change always passes a closed gate, so no runt pulse reaches the clock; reset loads cur 0 with the gate open
    always_comb
    begin
        next_st = st;
        case (st.state)
            scs_pkg::SW_RUN:
            begin
                if (req_in != st.cur)
                begin
                    next_st.state = scs_pkg::SW_GAP;
                    next_st.cnt = scs_pkg::SETTLE_W'(scs_pkg::SETTLE_CYC - 1);
                end
            end
            scs_pkg::SW_GAP:
            begin
                if (st.cnt == '0)
                begin
                    next_st.cur = req_in;
                    next_st.state = scs_pkg::SW_RUN;
                end
                else
                begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
            default:
            begin
                next_st.state = scs_pkg::SW_RUN;
            end
        endcase
        if (rst_in)
        begin
            next_st.state = scs_pkg::SW_RUN;
            next_st.cnt = '0;
            next_st.cur = '0;
        end
    end

    // State register
    always_ff @(posedge mclk_in)
    begin
        st <= next_st;
    end

    assign sel_out = st.cur;
    assign gate_out = (st.state == scs_pkg::SW_RUN);
endmodule : scs_glitchless

// ==== logic/scs_pkg.sv ====
// Shared constants, register map and carrier types of the clock source switcher
package scs_pkg;
    // Register indices on the 3-bit register port
    localparam logic [2:0] ADDR_RUN = 3'h0;
    localparam logic [2:0] ADDR_SUPPLY = 3'h1;
    localparam logic [2:0] ADDR_MODE = 3'h2;
    localparam logic [2:0] ADDR_SEL = 3'h3;
    localparam logic [2:0] ADDR_SUBSRC = 3'h4;
    localparam logic [2:0] ADDR_STABSEL = 3'h5;
    localparam logic [2:0] ADDR_STABCNT = 3'h6;
    // clock_run_control bit positions
    localparam int RUN_MAIN_HALT = 7;
    localparam int RUN_SUB_HALT = 6;
    localparam int RUN_MID_EN = 1;
    localparam int RUN_HS_HALT = 0;
    // subclock_supply_control bit positions
    localparam int SUP_LOW_POWER = 7;
    localparam int SUP_IT_LOWOSC = 4;
    localparam int SUP_HS_PREC = 0;
    // oscillator_mode_control bit positions
    localparam int MODE_MAIN_EXT = 7;
    localparam int MODE_MAIN_XTAL = 6;
    localparam int MODE_SUB_EXT = 5;
    localparam int MODE_SUB_XTAL = 4;
    localparam int MODE_SUB_HI = 2;
    localparam int MODE_SUB_LO = 1;
    localparam int MODE_GAIN = 0;
    // clock_select_control bit positions
    localparam int SEL_SUB_STAT = 7;
    localparam int SEL_SUB = 6;
    localparam int SEL_EXT_STAT = 5;
    localparam int SEL_EXT = 4;
    localparam int SEL_MID_STAT = 1;
    localparam int SEL_MID = 0;
    // Values after reset: both crystals halted, high-speed oscillator running
    localparam logic [7:0] RUN_RST = 8'hc0;
    localparam logic [7:0] ZERO_RST = 8'h00;
    // Stabilization exponents of status bits 7 down to 0
    localparam logic [7:0][4:0] STAB_EXP = {5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0d, 5'h0f, 5'h11, 5'h12};
    localparam int STAB_CNT_W = 19;
    // Dead time of a clock mux change
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 3;
    // Mux change sequencer states
    typedef enum logic [1:0] {
        SW_RUN = 2'b01,
        SW_GAP = 2'b10
    } scs_sw_e;
    // Main clock pin configuration
    typedef struct packed {
        logic xtal_mode;
        logic ext_clock;
        logic gain_high;
    } scs_main_pins_s;
    // Subsystem clock pin configuration
    typedef struct packed {
        logic xtal_mode;
        logic ext_clock;
        logic drive_hi;
        logic drive_lo;
        logic low_power_default;
    } scs_sub_pins_s;
    // Register state of the top module
    typedef struct packed {
        logic main_xtal_halt;
        logic sub_xtal_halt;
        logic mid_osc_enable;
        logic hs_osc_halt;
        logic sub_periph_low_power;
        logic interval_timer_lowosc_clock;
        logic [7:0] mode;
        logic mode_written;
        logic sub_select;
        logic main_ext_select;
        logic main_mid_select;
        logic low_osc_select;
        logic [2:0] stab_sel;
        logic [STAB_CNT_W-1:0] stab_cnt;
        logic [7:0] rdata;
    } scs_top_s;
endpackage : scs_pkg

// ==== logic/scs_switcher.sv ====
// Clock source switcher: control registers, stabilization counter and source muxes
//
// Contract
// - Writing sub_select 1 moves the CPU/peripheral clock to the subsystem clock.
// - While sub_select is 1, main_ext_select and main_mid_select cannot change.
// - sub_status reads 1 only once the CPU clock really runs from subsystem.
// - main_ext_status reads 1 once the main clock runs from the high-speed system clock.
// - main_ext_select 1 makes the high-speed system clock the main clock source.
// - Selects 0 and 1 choose the middle-speed oscillator as main on-chip clock.
// - Both selects 0 choose the high-speed oscillator as main on-chip clock.
// - hs_osc_halt 0 runs the high-speed oscillator, 1 stops it.
// - mid_osc_enable 1 runs the middle-speed oscillator, 0 stops it.
// - sub_xtal_halt 0 starts the subsystem oscillator; external clock must come first.
// - main_xtal_halt 0 starts the main oscillator; external clock must come first.
// - oscillator_mode_control takes one write after reset, later writes are ignored.
// - Main pins: crystal mode when selected, external clock input when also flagged.
// - Subsystem pins: crystal mode when selected, external clock when also flagged.
// - Both subsystem drive bits 0 give the default low-power oscillation.
// - Three-bit stabilize_time_select chooses the main crystal stabilization wait.
// - stable_count bits set progressively after the main crystal starts.
// - Clearing low_osc_select stops the low-speed oscillator unless otherwise needed.
// - interval_timer_lowosc_clock 1 keeps the low-speed oscillator running.
// - sub_periph_low_power 0 keeps peripherals on subsystem clock in STOP or HALT.
//
// Local design decisions: the strobed register port and the placing of the registers.
module scs_switcher #(
    // Lowers every stabilization exponent, so simulations can shorten the wait
    parameter int unsigned STAB_SHRINK = 0
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Oscillator status and standby request
    input wire logic hs_osc_stable_in,
    input wire logic standby_in,
    // Oscillator run controls
    output logic hs_osc_run_out,
    output logic mid_osc_run_out,
    output logic low_osc_run_out,
    output logic main_xtal_run_out,
    output logic sub_xtal_run_out,
    // Pin configurations
    output scs_pkg::scs_main_pins_s main_pins_out,
    output scs_pkg::scs_sub_pins_s sub_pins_out,
    // Clock mux controls
    output logic main_src_ext_out,
    output logic main_src_mid_out,
    output logic main_gate_out,
    output logic cpu_src_sub_out,
    output logic cpu_gate_out,
    output logic periph_sub_clk_out
);
    scs_pkg::scs_top_s st;
    scs_pkg::scs_top_s next_st;
    logic hs_prec;
    logic [7:0] stab_bits;
    logic stab_done;
    logic count_en;
    logic main_ext_ready;
    logic [1:0] main_req;
    logic [1:0] main_sel;
    logic sub_status;
    logic [7:0] run_rd;
    logic [7:0] sup_rd;
    logic [7:0] sel_rd;

    // Oscillator precision flag is an asynchronous level from the analog side
    scs_sync #(
        .W(1)
    ) u_prec_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(hs_osc_stable_in),
        .sync_out(hs_prec)
    );

    // Main clock mux, code {external, middle}
    scs_glitchless #(
        .W(2)
    ) u_main_mux (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .req_in(main_req),
        .sel_out(main_sel),
        .gate_out(main_gate_out)
    );

    // CPU/peripheral mux, main or subsystem
    scs_glitchless #(
        .W(1)
    ) u_cpu_mux (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .req_in(st.sub_select),
        .sel_out(sub_status),
        .gate_out(cpu_gate_out)
    );

    // Stabilization thresholds, one per status bit
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_stab
            localparam logic [4:0] EXP_I = 5'(scs_pkg::STAB_EXP[i] - 5'(STAB_SHRINK));
            assign stab_bits[i] = (st.stab_cnt >= (scs_pkg::STAB_CNT_W'(1) << EXP_I));
        end
    endgenerate

    // Selected wait: value v picks bit 7-v, which is the bitwise inverse
    assign stab_done = stab_bits[~st.stab_sel];
    assign count_en = !st.main_xtal_halt && st.mode[scs_pkg::MODE_MAIN_XTAL] && !st.mode[scs_pkg::MODE_MAIN_EXT];
    // An external main clock needs no wait, only the pins and the run bit
    assign main_ext_ready = st.mode[scs_pkg::MODE_MAIN_EXT] ? !st.main_xtal_halt : stab_done;
    // Hold the mux on its old source until the crystal is usable
    assign main_req = {st.main_ext_select && main_ext_ready, st.main_mid_select};

    // Read images; status bits come from the committed mux codes
    assign run_rd = {st.main_xtal_halt, st.sub_xtal_halt, 4'h0, st.mid_osc_enable, st.hs_osc_halt};
    assign sup_rd = {st.sub_periph_low_power, 2'h0, st.interval_timer_lowosc_clock, 3'h0, hs_prec};
    assign sel_rd = {sub_status, st.sub_select, main_sel[1], st.main_ext_select, 2'h0, main_sel[0],
                     st.main_mid_select};

    // Register file, read data and stabilization counter
    always_comb
    begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (rd_in)
        begin
            case (addr_in)
                scs_pkg::ADDR_RUN: next_st.rdata = run_rd;
                scs_pkg::ADDR_SUPPLY: next_st.rdata = sup_rd;
                scs_pkg::ADDR_MODE: next_st.rdata = st.mode;
                scs_pkg::ADDR_SEL: next_st.rdata = sel_rd;
                scs_pkg::ADDR_SUBSRC: next_st.rdata = {7'h00, st.low_osc_select};
                scs_pkg::ADDR_STABSEL: next_st.rdata = {5'h00, st.stab_sel};
                scs_pkg::ADDR_STABCNT: next_st.rdata = stab_bits;
                default: next_st.rdata = 8'h00;
            endcase
        end
        if (wr_in)
        begin
            case (addr_in)
                scs_pkg::ADDR_RUN:
                begin
                    next_st.main_xtal_halt = wdata_in[scs_pkg::RUN_MAIN_HALT];
                    next_st.sub_xtal_halt = wdata_in[scs_pkg::RUN_SUB_HALT];
                    next_st.mid_osc_enable = wdata_in[scs_pkg::RUN_MID_EN];
                    next_st.hs_osc_halt = wdata_in[scs_pkg::RUN_HS_HALT];
                end
                scs_pkg::ADDR_SUPPLY:
                begin
                    next_st.sub_periph_low_power = wdata_in[scs_pkg::SUP_LOW_POWER];
                    next_st.interval_timer_lowosc_clock = wdata_in[scs_pkg::SUP_IT_LOWOSC];
                end
                scs_pkg::ADDR_MODE:
                begin
                    // Locks after the first write so a stray store cannot retune pins
                    if (!st.mode_written)
                    begin
                        next_st.mode = wdata_in;
                        next_st.mode_written = 1'b1;
                    end
                end
                scs_pkg::ADDR_SEL:
                begin
                    next_st.sub_select = wdata_in[scs_pkg::SEL_SUB];
                    // Main selects are frozen while sub_select is 1, whether or not the CPU mux has committed yet
                    if (!st.sub_select)
                    begin
                        next_st.main_ext_select = wdata_in[scs_pkg::SEL_EXT];
                        next_st.main_mid_select = wdata_in[scs_pkg::SEL_MID];
                    end
                end
                scs_pkg::ADDR_SUBSRC:
                begin
                    next_st.low_osc_select = wdata_in[0];
                end
                scs_pkg::ADDR_STABSEL:
                begin
                    next_st.stab_sel = wdata_in[2:0];
                end
                default:
                begin
                    next_st.stab_sel = st.stab_sel;
                end
            endcase
        end
        // Counts from crystal start, saturates at the longest wait, clears on halt
        if (!count_en)
        begin
            next_st.stab_cnt = '0;
        end
        else if (!stab_bits[0])
        begin
            next_st.stab_cnt = st.stab_cnt + 1'b1;
        end
        if (rst_in)
        begin
            next_st = '0;
            next_st.main_xtal_halt = scs_pkg::RUN_RST[scs_pkg::RUN_MAIN_HALT];
            next_st.sub_xtal_halt = scs_pkg::RUN_RST[scs_pkg::RUN_SUB_HALT];
            next_st.mode = scs_pkg::ZERO_RST;
        end
    end

    // State register
    always_ff @(posedge mclk_in)
    begin
        st <= next_st;
    end

    // Oscillator controls
    assign hs_osc_run_out = !st.hs_osc_halt;
    assign mid_osc_run_out = st.mid_osc_enable;
    assign main_xtal_run_out = !st.main_xtal_halt;
    assign sub_xtal_run_out = !st.sub_xtal_halt;
    // The interval timer keeps its clock even after the select is cleared
    assign low_osc_run_out = st.low_osc_select || st.interval_timer_lowosc_clock;

    // Pin modes; external input needs the crystal-mode bit as well
    assign main_pins_out.xtal_mode = st.mode[scs_pkg::MODE_MAIN_XTAL] && !st.mode[scs_pkg::MODE_MAIN_EXT];
    assign main_pins_out.ext_clock = st.mode[scs_pkg::MODE_MAIN_XTAL] && st.mode[scs_pkg::MODE_MAIN_EXT];
    assign main_pins_out.gain_high = st.mode[scs_pkg::MODE_GAIN];
    assign sub_pins_out.xtal_mode = st.mode[scs_pkg::MODE_SUB_XTAL] && !st.mode[scs_pkg::MODE_SUB_EXT];
    assign sub_pins_out.ext_clock = st.mode[scs_pkg::MODE_SUB_XTAL] && st.mode[scs_pkg::MODE_SUB_EXT];
    assign sub_pins_out.drive_hi = st.mode[scs_pkg::MODE_SUB_HI];
    assign sub_pins_out.drive_lo = st.mode[scs_pkg::MODE_SUB_LO];
    assign sub_pins_out.low_power_default = !st.mode[scs_pkg::MODE_SUB_HI] && !st.mode[scs_pkg::MODE_SUB_LO];

    // Committed mux codes and standby peripheral clock
    assign main_src_ext_out = main_sel[1];
    assign main_src_mid_out = !main_sel[1] && main_sel[0];
    assign cpu_src_sub_out = sub_status;
    assign periph_sub_clk_out = sub_status && !(standby_in && st.sub_periph_low_power);
    assign rdata_out = st.rdata;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_sub_req;
        wr_in && addr_in == scs_pkg::ADDR_SEL && wdata_in[scs_pkg::SEL_SUB] && !st.sub_select;
    endsequence
    sequence s_sel_write_locked;
        wr_in && addr_in == scs_pkg::ADDR_SEL && st.sub_select;
    endsequence
    sequence s_mode_late;
        wr_in && addr_in == scs_pkg::ADDR_MODE && st.mode_written;
    endsequence

    a_sub_switch_time: assert property (s_sub_req ##1 st.sub_select[*6] |-> ##[1:7] sub_status)
        else $error("subsystem switch did not commit in time");
    a_main_sel_frozen: assert property (s_sel_write_locked |=>
        $stable(st.main_ext_select) && $stable(st.main_mid_select))
        else $error("main select changed while subsystem selected");
    a_sub_status_gap: assert property ($changed(sub_status) |-> $past(!cpu_gate_out))
        else $error("sub status changed outside the gated gap");
    a_ext_status_ready: assert property ($rose(main_src_ext_out) |-> $past(main_ext_ready) && st.main_ext_select)
        else $error("main clock moved to external before ready");
    a_hs_halt_write: assert property (wr_in && addr_in == scs_pkg::ADDR_RUN |=>
        hs_osc_run_out == !$past(wdata_in[scs_pkg::RUN_HS_HALT])
        && mid_osc_run_out == $past(wdata_in[scs_pkg::RUN_MID_EN]))
        else $error("oscillator run bits not taken");
    a_mode_write_once: assert property (s_mode_late |=> $stable(st.mode))
        else $error("mode register changed after its single write");
    a_stab_monotonic: assert property (count_en && $past(count_en) |-> (stab_bits & $past(stab_bits)) == $past(stab_bits))
        else $error("stable count bit fell while counting");
    a_low_osc_kept: assert property (st.interval_timer_lowosc_clock |-> low_osc_run_out)
        else $error("low-speed oscillator stopped under interval timer");
    a_main_gap_len: assert property ($fell(main_gate_out) |-> !main_gate_out[*5] ##1 main_gate_out)
        else $error("main mux gap has wrong length");
endmodule : scs_switcher

// ==== logic/scs_sync.sv ====
// Two-flop synchronizer for levels arriving from outside the clock domain
module scs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } scs_sync_s;

    scs_sync_s st;
    scs_sync_s next_st;

    // The first stage feeds only the second one
    always_comb
    begin
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        if (rst_in)
        begin
            next_st = '0;
        end
    end

    // State register
    always_ff @(posedge mclk_in)
    begin
        st <= next_st;
    end

    assign sync_out = st.s2;
endmodule : scs_sync

// ==== testbench/scs_switcher_test.sv ====
// Self-checking bench of the clock source switcher: register port, oscillator controls and muxes
module scs_switcher_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened stabilization: the last status bit needs 2^10 cycles
    localparam int unsigned SHRINK = 8;
    typedef struct packed {logic [7:0] wdata; logic [3:0] runs;} scs_row_s;
    logic mclk_in, rst_in, wr_in, rd_in, hs_osc_stable_in, standby_in;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata_out, got;
    logic hs_osc_run_out, mid_osc_run_out, low_osc_run_out, main_xtal_run_out, sub_xtal_run_out;
    logic main_src_ext_out, main_src_mid_out, main_gate_out, cpu_src_sub_out, cpu_gate_out, periph_sub_clk_out;
    scs_pkg::scs_main_pins_s main_pins_out;
    scs_pkg::scs_sub_pins_s sub_pins_out;
    int fail_count = 0;
    int checks = 0;
    int n;
    // Run control rows: written value and {main, sub, mid, hs} run outputs
    scs_row_s rows [7] = '{'{8'h00, 4'hd}, '{8'h01, 4'hc}, '{8'h02, 4'hf}, '{8'h80, 4'h5},
        '{8'h40, 4'h9}, '{8'hc3, 4'h2}, '{8'hc0, 4'h1}};

    scs_switcher #(.STAB_SHRINK(SHRINK)) u_scs_switcher (.mclk_in(mclk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .hs_osc_stable_in(hs_osc_stable_in), .standby_in(standby_in), .hs_osc_run_out(hs_osc_run_out),
        .mid_osc_run_out(mid_osc_run_out), .low_osc_run_out(low_osc_run_out),
        .main_xtal_run_out(main_xtal_run_out), .sub_xtal_run_out(sub_xtal_run_out),
        .main_pins_out(main_pins_out), .sub_pins_out(sub_pins_out), .main_src_ext_out(main_src_ext_out),
        .main_src_mid_out(main_src_mid_out), .main_gate_out(main_gate_out),
        .cpu_src_sub_out(cpu_src_sub_out), .cpu_gate_out(cpu_gate_out),
        .periph_sub_clk_out(periph_sub_clk_out));

    // Free-running 25 MHz clock
    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    task chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask : chk8

    task chk1(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask : chk1

    // One-cycle write strobe; returns at the edge that takes it
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are sampled there
    task rd(input logic [2:0] a);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask : rd

    // Lands in the last gap cycle of a mux change taken by the preceding write
    task gap6;
        repeat (5) @(posedge mclk_in);
        #1;
    endtask : gap6

    task do_reset;
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        #1;
    endtask : do_reset

    task give_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // Watchdog: the whole sequence needs well under 5000 cycles
    initial
    begin
        #800000;
        fail_count++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        hs_osc_stable_in = 1'b0;
        standby_in = 1'b0;
        do_reset();
        chk8({hs_osc_run_out, mid_osc_run_out, low_osc_run_out, main_xtal_run_out, sub_xtal_run_out,
            main_src_ext_out, main_src_mid_out, cpu_src_sub_out}, 8'h80);
        chk8({main_pins_out, sub_pins_out}, 8'h01);
        chk8({6'h00, main_gate_out, cpu_gate_out}, 8'h03);
        chk1(periph_sub_clk_out, 1'b0);
        rd(scs_pkg::ADDR_RUN);
        chk8(got, scs_pkg::RUN_RST);
        rd(scs_pkg::ADDR_STABCNT);
        chk8(got, 8'h00);
        // Read data stand one cycle only, then fall back to zero
        @(posedge mclk_in);
        #1 chk8(rdata_out, 8'h00);
        // Unmapped index neither stores nor answers
        wr(3'h7, 8'hff);
        rd(3'h7);
        chk8(got, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 7; i++)
        begin
            wr(scs_pkg::ADDR_RUN, rows[i].wdata);
            #1 chk8({4'h0, main_xtal_run_out, sub_xtal_run_out, mid_osc_run_out, hs_osc_run_out},
                {4'h0, rows[i].runs});
            rd(scs_pkg::ADDR_RUN);
            chk8(got, rows[i].wdata & 8'hc3);
        end
        $display("test run control done");
        wr(scs_pkg::ADDR_SUBSRC, 8'h01);
        #1 chk1(low_osc_run_out, 1'b1);
        wr(scs_pkg::ADDR_SUPPLY, 8'h10);
        wr(scs_pkg::ADDR_SUBSRC, 8'h00);
        #1 chk1(low_osc_run_out, 1'b1);
        wr(scs_pkg::ADDR_SUPPLY, 8'h00);
        #1 chk1(low_osc_run_out, 1'b0);
        @(posedge mclk_in);
        hs_osc_stable_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rd(scs_pkg::ADDR_SUPPLY);
        chk8(got, 8'h01);
        $display("test low oscillator and precision done");
        // Mode register takes only its first write after reset
        wr(scs_pkg::ADDR_MODE, 8'h56);
        #1 chk8({main_pins_out, sub_pins_out}, 8'h96);
        wr(scs_pkg::ADDR_MODE, 8'hff);
        rd(scs_pkg::ADDR_MODE);
        chk8(got, 8'h56);
        chk8({main_pins_out, sub_pins_out}, 8'h96);
        $display("test mode write-once done");
        wr(scs_pkg::ADDR_SEL, 8'h01);
        gap6();
        chk1(main_gate_out, 1'b0);
        chk1(main_src_mid_out, 1'b0);
        @(posedge mclk_in);
        #1 chk1(main_src_mid_out, 1'b1);
        chk1(main_gate_out, 1'b1);
        rd(scs_pkg::ADDR_SEL);
        chk8(got, 8'h03);
        wr(scs_pkg::ADDR_SEL, 8'h00);
        repeat (8) @(posedge mclk_in);
        #1 chk8({6'h00, main_src_ext_out, main_src_mid_out}, 8'h00);
        rd(scs_pkg::ADDR_SEL);
        chk8(got, 8'h00);
        $display("test middle oscillator switch done");
        // Reset in mid-run reopens the mode register; external inputs on both pin pairs
        do_reset();
        rd(scs_pkg::ADDR_MODE);
        chk8(got, 8'h00);
        wr(scs_pkg::ADDR_MODE, 8'hf1);
        #1 chk8({main_pins_out, sub_pins_out}, 8'h69);
        $display("test external pin modes done");
        do_reset();
        wr(scs_pkg::ADDR_MODE, 8'h40);
        wr(scs_pkg::ADDR_SEL, 8'h10);
        repeat (10) @(posedge mclk_in);
        #1 chk1(main_src_ext_out, 1'b0);
        wr(scs_pkg::ADDR_STABSEL, 8'h07);
        wr(scs_pkg::ADDR_RUN, 8'h40);
        repeat (20) @(posedge mclk_in);
        rd(scs_pkg::ADDR_STABCNT);
        chk8(got, 8'hf0);
        chk1(main_src_ext_out, 1'b0);
        n = 0;
        do
        begin
            rd(scs_pkg::ADDR_STABCNT);
            n++;
        end
        while (got !== 8'hff && n < 1000);
        chk8(got, 8'hff);
        n = 0;
        while (main_src_ext_out !== 1'b1 && n < 20)
        begin
            @(posedge mclk_in);
            #1 n++;
        end
        chk1(main_src_ext_out, 1'b1);
        rd(scs_pkg::ADDR_SEL);
        chk8(got, 8'h30);
        $display("test crystal stabilization done");
        wr(scs_pkg::ADDR_SEL, 8'h50);
        gap6();
        chk1(cpu_gate_out, 1'b0);
        chk1(cpu_src_sub_out, 1'b0);
        @(posedge mclk_in);
        #1 chk1(cpu_src_sub_out, 1'b1);
        rd(scs_pkg::ADDR_SEL);
        chk8(got, 8'hf0);
        // Main selects frozen while the subsystem clock drives the CPU
        wr(scs_pkg::ADDR_SEL, 8'h41);
        repeat (10) @(posedge mclk_in);
        #1 chk8({6'h00, main_src_ext_out, main_src_mid_out}, 8'h02);
        rd(scs_pkg::ADDR_SEL);
        chk8(got, 8'hf0);
        @(posedge mclk_in);
        standby_in <= 1'b1;
        @(posedge mclk_in);
        #1 chk1(periph_sub_clk_out, 1'b1);
        wr(scs_pkg::ADDR_SUPPLY, 8'h80);
        #1 chk1(periph_sub_clk_out, 1'b0);
        @(posedge mclk_in);
        standby_in <= 1'b0;
        @(posedge mclk_in);
        #1 chk1(periph_sub_clk_out, 1'b1);
        wr(scs_pkg::ADDR_SEL, 8'h10);
        repeat (8) @(posedge mclk_in);
        #1 chk1(cpu_src_sub_out, 1'b0);
        $display("test subsystem switch done");
        give_verdict();
    end
endmodule : scs_switcher_test
